// ### logic/exc_consts.vh
/*
 Constants for the exception unit: APB offsets, machine-state bit positions,
 syndrome bit positions, vector offsets and reset values.
 Assumes a 32-bit APB register bus with word-aligned registers.
*/
`ifndef EXC_CONSTS_VH
`define EXC_CONSTS_VH

// Register byte addresses
`define OFF_MACHINE_STATE  12'h000
`define OFF_SAVE_ADDR      12'h004
`define OFF_SAVE_STATE     12'h008
`define OFF_VECTOR_PREFIX  12'h00c
`define OFF_FAULT_ADDR     12'h010
`define OFF_SYNDROME       12'h014
`define OFF_STATUS         12'h018
`define OFF_PC             12'h01c

// Machine-state bit positions (bit 0 is the least significant)
`define MS_AUX_AVAIL   25
`define MS_AUX_EXC_EN  19
`define MS_WAIT        18
`define MS_CRIT_EN     17
`define MS_EXT_EN      15
`define MS_PROBLEM     14
`define MS_FLOAT_AVAIL 13
`define MS_MCHK_EN     12
`define MS_FE0         11
`define MS_DWE         10
`define MS_DBG_EN      9
`define MS_FE1         8
`define MS_IR          5
`define MS_DR          4

// Bits cleared on entry to every handler covered here
`define MS_CLEAR_MASK  32'h020ced30

// Syndrome bit positions
`define SY_MCHK        31
`define SY_ILLEGAL     27
`define SY_PRIV        26
`define SY_TRAP        25
`define SY_FLOAT       24
`define SY_AUX         23
`define SY_UNIMPL      22
`define SY_KEEP_MASK   32'h80000000

// Vector offsets
`define VEC_ALIGN      16'h0600
`define VEC_PROGRAM    16'h0700
`define VEC_FLOAT_UNAV 16'h0800

// Reset values
`define MS_RESET       32'h00000000
`define PREFIX_RESET   16'h0000
`define PC_RESET       32'hfffffffc

`endif

// ### logic/exc_detect.v
/*
 Combinational classifier for one instruction in the execute slot: decides
 whether it takes an alignment, program or floating-point unavailable fault.
 Assumes decode and coprocessor inputs are stable and synchronous to pclk.
*/
`timescale 1ns/100ps
`default_nettype none

module exc_detect (
    input  wire        is_block_zero,
    input  wire        nocache_or_wt,
    input  wire        is_word_excl,
    input  wire        is_copro_ls,
    input  wire [1:0]  ls_size,
    input  wire        is_float_instr,
    input  wire [31:0] data_addr,
    input  wire        opcode_illegal,
    input  wire        is_privileged,
    input  wire        is_tlb_instr,
    input  wire        is_trap,
    input  wire        trap_cond,
    input  wire        problem_state,
    input  wire        float_available,
    input  wire        mmu_present_tie,
    input  wire        aux_exception_in,
    input  wire        float_exception_in,
    input  wire        aux_decoded_op,
    input  wire        float_decoded_op,
    input  wire        coproc_valid_op,
    output wire        align_fault,
    output wire        float_unav,
    output reg  [5:0]  prog_cause
);

    // Alignment faults; size 0 half, 1 word, 2 double, 3 quad
    wire misalign_ls = is_copro_ls &&
        ((ls_size == 2'd0 && data_addr[0]) ||
         ((ls_size == 2'd1 || ls_size == 2'd2) && data_addr[1:0] != 2'd0) ||
         (ls_size == 2'd3 && data_addr[3:0] != 4'h0));
    assign align_fault = (is_block_zero && nocache_or_wt) ||
                         (is_word_excl && data_addr[1:0] != 2'd0) ||
                         misalign_ls;

    assign float_unav = float_decoded_op && !float_available;

    // One-hot cause, first match wins: illegal, priv, trap, unimpl, float, aux
    always @* begin
        prog_cause = 6'h00;
        if (opcode_illegal || (is_tlb_instr && !mmu_present_tie)) begin
            prog_cause = 6'h20;
        end else if (is_privileged && problem_state) begin
            prog_cause = 6'h10;
        end else if (is_trap && trap_cond) begin
            prog_cause = 6'h08;
        end else if ((aux_decoded_op || float_decoded_op) && !coproc_valid_op) begin
            prog_cause = 6'h04;
        end else if (float_decoded_op && float_exception_in) begin
            prog_cause = 6'h02;
        end else if (aux_decoded_op && aux_exception_in) begin
            prog_cause = 6'h01;
        end
    end

endmodule

`default_nettype wire

// ### logic/exc_unit.v
/*
 Exception unit for alignment, program and floating-point unavailable faults.
 Holds machine state, save-restore pair, vector prefix, fault address and
 syndrome; redirects the program counter. Software reaches registers by APB.
 Assumes the pipeline presents one instruction per instr_valid pulse and
 honours instr_block in the same cycle.
*/
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "exc_consts.vh"

module exc_unit #(
    parameter [31:0] RESET_PC = `PC_RESET
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        instr_valid,
    input  wire [31:0] instr_addr,
    input  wire        is_rfi,
    input  wire        is_block_zero,
    input  wire        nocache_or_wt,
    input  wire        is_word_excl,
    input  wire        is_copro_ls,
    input  wire [1:0]  ls_size,
    input  wire        is_float_instr,
    input  wire [31:0] data_addr,
    input  wire        opcode_illegal,
    input  wire        is_privileged,
    input  wire        is_tlb_instr,
    input  wire        is_trap,
    input  wire        trap_cond,
    input  wire        mmu_present_tie,
    input  wire        aux_exception_in,
    input  wire        float_exception_in,
    input  wire        aux_decoded_op,
    input  wire        float_decoded_op,
    input  wire        coproc_valid_op,
    output wire        instr_block,
    output reg         redirect,
    output reg  [31:0] pc_r
);

    reg  [31:0] machine_state_r;
    reg  [31:0] save_restore_addr_r;
    reg  [31:0] save_restore_state_r;
    reg  [15:0] vector_prefix_r;
    reg  [31:0] fault_data_addr_r;
    reg  [31:0] syndrome_r;
    reg  [1:0]  last_class_r;
    reg  [7:0]  fault_count_r;

    wire        align_fault;
    wire        float_unav;
    wire [5:0]  prog_cause;

    // Entry value of machine state, shared by all three classes
    function [31:0] entry_state;
        input [31:0] ms;
        begin
            entry_state = ms & ~`MS_CLEAR_MASK;
        end
    endfunction

    // Syndrome image for a program cause, machine-check bit kept
    function [31:0] cause_syndrome;
        input [31:0] old;
        input [5:0]  cause;
        reg   [31:0] s;
        begin
            s = old & `SY_KEEP_MASK;
            s[`SY_ILLEGAL] = cause[5];
            s[`SY_PRIV]    = cause[4];
            s[`SY_TRAP]    = cause[3];
            s[`SY_UNIMPL]  = cause[2];
            s[`SY_FLOAT]   = cause[1];
            s[`SY_AUX]     = cause[0];
            cause_syndrome = s;
        end
    endfunction

    exc_detect u_detect (
        .is_block_zero      (is_block_zero),
        .nocache_or_wt      (nocache_or_wt),
        .is_word_excl       (is_word_excl),
        .is_copro_ls        (is_copro_ls),
        .ls_size            (ls_size),
        .is_float_instr     (is_float_instr),
        .data_addr          (data_addr),
        .opcode_illegal     (opcode_illegal),
        .is_privileged      (is_privileged),
        .is_tlb_instr       (is_tlb_instr),
        .is_trap            (is_trap),
        .trap_cond          (trap_cond),
        .problem_state      (machine_state_r[`MS_PROBLEM]),
        .float_available    (machine_state_r[`MS_FLOAT_AVAIL]),
        .mmu_present_tie    (mmu_present_tie),
        .aux_exception_in   (aux_exception_in),
        .float_exception_in (float_exception_in),
        .aux_decoded_op     (aux_decoded_op),
        .float_decoded_op   (float_decoded_op),
        .coproc_valid_op    (coproc_valid_op),
        .align_fault        (align_fault),
        .float_unav         (float_unav),
        .prog_cause         (prog_cause)
    );

    // Fault priority: program, then float unavailable, then alignment
    wire take_prog  = instr_valid && (prog_cause != 6'h00);
    wire take_funav = instr_valid && !take_prog && float_unav;
    wire take_align = instr_valid && !take_prog && !float_unav && align_fault;
    wire take_any   = take_prog || take_funav || take_align;
    wire take_rfi   = instr_valid && is_rfi && !take_any;

    // Offending instruction must not complete
    assign instr_block = take_any;

    // APB: zero wait states, never errors; unmapped reads return zero
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    wire apb_wr = psel && penable && pwrite;

    // Vector target for the class being taken
    reg [15:0] vec_low;
    always @* begin
        if (take_prog) begin
            vec_low = `VEC_PROGRAM;
        end else if (take_funav) begin
            vec_low = `VEC_FLOAT_UNAV;
        end else begin
            vec_low = `VEC_ALIGN;
        end
    end

    // Architected state; hardware entry wins over a same-cycle bus write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            machine_state_r      <= `MS_RESET;
            save_restore_addr_r  <= 32'h00000000;
            save_restore_state_r <= 32'h00000000;
            vector_prefix_r      <= `PREFIX_RESET;
            fault_data_addr_r    <= 32'h00000000;
            syndrome_r           <= 32'h00000000;
            pc_r                 <= RESET_PC;
            redirect             <= 1'b0;
            last_class_r         <= 2'd0;
            fault_count_r        <= 8'h00;
        end else begin
            redirect <= take_any || take_rfi;
            if (take_any) begin
                save_restore_addr_r  <= instr_addr;
                save_restore_state_r <= machine_state_r;
                machine_state_r      <= entry_state(machine_state_r);
                pc_r                 <= {vector_prefix_r, vec_low};
                fault_count_r        <= fault_count_r + 8'h01;
                if (take_prog) begin
                    syndrome_r   <= cause_syndrome(syndrome_r, prog_cause);
                    last_class_r <= 2'd1;
                end else if (take_funav) begin
                    last_class_r <= 2'd2;
                end else begin
                    fault_data_addr_r <= data_addr;
                    last_class_r      <= 2'd3;
                end
            end else if (take_rfi) begin
                pc_r            <= save_restore_addr_r;
                machine_state_r <= save_restore_state_r;
            end else begin
                if (instr_valid) begin
                    pc_r <= instr_addr + 32'h00000004;
                end
                if (apb_wr) begin
                    case (paddr)
                        `OFF_MACHINE_STATE: machine_state_r      <= pwdata;
                        `OFF_SAVE_ADDR:     save_restore_addr_r  <= pwdata;
                        `OFF_SAVE_STATE:    save_restore_state_r <= pwdata;
                        `OFF_VECTOR_PREFIX: vector_prefix_r      <= pwdata[15:0];
                        `OFF_FAULT_ADDR:    fault_data_addr_r    <= pwdata;
                        `OFF_SYNDROME:      syndrome_r           <= pwdata;
                        default: ;
                    endcase
                end
            end
        end
    end

    // Read data registered during setup so it is stable in the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `OFF_MACHINE_STATE: prdata <= machine_state_r;
                `OFF_SAVE_ADDR:     prdata <= save_restore_addr_r;
                `OFF_SAVE_STATE:    prdata <= save_restore_state_r;
                `OFF_VECTOR_PREFIX: prdata <= {16'h0000, vector_prefix_r};
                `OFF_FAULT_ADDR:    prdata <= fault_data_addr_r;
                `OFF_SYNDROME:      prdata <= syndrome_r;
                `OFF_STATUS:        prdata <= {22'h000000, last_class_r, fault_count_r};
                `OFF_PC:            prdata <= pc_r;
                default:            prdata <= 32'h00000000;
            endcase
        end
    end

endmodule

`default_nettype wire

// ### test/exc_unit_assertions.sv
/*
 Checker for the exception unit, bound to its top module.
 Assumes one pclk domain with asynchronous active-low presetn.
*/
`timescale 1ns/100ps
`default_nettype none
module exc_unit_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        instr_valid,
    input wire logic        is_block_zero,
    input wire logic        nocache_or_wt,
    input wire logic        is_word_excl,
    input wire logic        is_copro_ls,
    input wire logic [1:0]  ls_size,
    input wire logic [31:0] data_addr,
    input wire logic        opcode_illegal,
    input wire logic        is_privileged,
    input wire logic        is_tlb_instr,
    input wire logic        is_trap,
    input wire logic        trap_cond,
    input wire logic        mmu_present_tie,
    input wire logic        float_exception_in,
    input wire logic        aux_decoded_op,
    input wire logic        float_decoded_op,
    input wire logic        coproc_valid_op,
    input wire logic        instr_block,
    input wire logic        redirect,
    input wire logic [31:0] pc_r
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // No program or coprocessor cause, so alignment decides alone
    wire logic quiet_c = !opcode_illegal && !is_privileged && !is_trap && !is_tlb_instr
                         && !aux_decoded_op && !float_decoded_op;
    wire logic ill_c = instr_valid && (opcode_illegal || (is_tlb_instr && !mmu_present_tie));
    wire logic ls_c = instr_valid && is_copro_ls && quiet_c && !is_block_zero && !is_word_excl;

    illegal_vec_a: assert property (ill_c |-> instr_block ##1 redirect && pc_r[15:0] == 16'h0700)
        else $error("illegal instruction not vectored");
    trap_vec_a: assert property (instr_valid && is_trap && trap_cond |-> instr_block ##1 pc_r[15:0] == 16'h0700)
        else $error("trap not vectored");
    zero_align_a: assert property (instr_valid && is_block_zero && nocache_or_wt && quiet_c |-> instr_block ##1 pc_r[15:0] == 16'h0600)
        else $error("block zero fault missed");
    no_valid_a: assert property (instr_valid && aux_decoded_op && !coproc_valid_op |-> instr_block ##1 pc_r[15:0] == 16'h0700)
        else $error("invalid coprocessor op missed");
    float_exc_a: assert property (instr_valid && float_decoded_op && float_exception_in |=> redirect && pc_r[15:0] == 16'h0700)
        else $error("float exception missed");
    vector_set_a: assert property (instr_valid && instr_block |=> redirect && pc_r[15:0] inside {16'h0600, 16'h0700, 16'h0800})
        else $error("blocked instruction without vector");
    idle_pc_a: assert property (!instr_valid |=> $stable(pc_r) && !redirect)
        else $error("counter moved without instruction");
    quad_align_a: assert property (ls_c && ls_size == 2'd3 && data_addr[3:0] != 4'h0 |-> instr_block)
        else $error("quadword misalignment missed");
    half_align_a: assert property (ls_c && ls_size == 2'd0 && data_addr[0] |-> instr_block)
        else $error("halfword misalignment missed");
    dword_ok_a: assert property (ls_c && ls_size == 2'd2 && data_addr[1:0] == 2'b00 |-> !instr_block)
        else $error("aligned doubleword blocked");
    // Main scenarios reached
    cover property (ill_c);
    cover property (redirect && pc_r[15:0] == 16'h0800);
    cover property (instr_valid && is_block_zero && nocache_or_wt);
endmodule
bind exc_unit exc_unit_checker chk_u (.pclk, .presetn, .instr_valid, .is_block_zero,
    .nocache_or_wt, .is_word_excl, .is_copro_ls, .ls_size, .data_addr, .opcode_illegal,
    .is_privileged, .is_tlb_instr, .is_trap, .trap_cond, .mmu_present_tie, .float_exception_in,
    .aux_decoded_op, .float_decoded_op, .coproc_valid_op, .instr_block, .redirect, .pc_r);
`default_nettype wire

// ### test/coproc_model.sv
/*
 Behavioural auxiliary and floating-point coprocessor decode side.
 Assumes the bench picks the operation kind in step with instr_valid.
*/
`timescale 1ns/100ps
`default_nettype none
module coproc_model (
    input  wire logic [1:0] op_kind,
    input  wire logic       op_impl,
    input  wire logic       op_reject,
    output wire logic       aux_decoded_op,
    output wire logic       float_decoded_op,
    output wire logic       coproc_valid_op,
    output wire logic       aux_exception_in,
    output wire logic       float_exception_in
);
    // Kind 1 is auxiliary, kind 2 floating point
    assign aux_decoded_op   = op_kind == 2'd1;
    assign float_decoded_op = op_kind == 2'd2;
    // Valid only for implemented operations
    assign coproc_valid_op  = (op_kind != 2'd0) && op_impl;
    // Rejection shows on the active unit's exception line
    assign aux_exception_in   = aux_decoded_op && op_reject;
    assign float_exception_in = float_decoded_op && op_reject;
endmodule
`default_nettype wire

// ### test/test_align_program_fpu_exceptions.sv
/*
 Self-checking bench for the exception unit with APB register access.
 Assumes zero-wait APB and faults visible the cycle after instr_valid.
*/
`timescale 1ns/100ps
`default_nettype none
`include "exc_consts.vh"
module test_align_program_fpu_exceptions;
    localparam logic [15:0] PFX = 16'h1234;
    localparam logic [31:0] MS  = 32'h020edf30;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, instr_addr, data_addr, pc_r, q;
    logic        instr_valid, is_rfi, is_block_zero, nocache_or_wt, is_word_excl, is_copro_ls;
    logic [1:0]  ls_size, op_kind;
    logic        is_float_instr, opcode_illegal, is_privileged, is_tlb_instr, is_trap;
    logic        trap_cond, mmu_present_tie, op_impl, op_reject, instr_block, redirect;
    logic        aux_exception_in, float_exception_in, aux_decoded_op, float_decoded_op;
    logic        coproc_valid_op;
    int          error_cnt, comparisons, i;
    int          sbit[7] = '{`SY_ILLEGAL, `SY_PRIV, `SY_TRAP, `SY_UNIMPL, `SY_FLOAT, `SY_AUX,
                             `SY_ILLEGAL};

    exc_unit dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .instr_valid, .instr_addr, .is_rfi, .is_block_zero, .nocache_or_wt,
        .is_word_excl, .is_copro_ls, .ls_size, .is_float_instr, .data_addr, .opcode_illegal,
        .is_privileged, .is_tlb_instr, .is_trap, .trap_cond, .mmu_present_tie,
        .aux_exception_in, .float_exception_in, .aux_decoded_op, .float_decoded_op,
        .coproc_valid_op, .instr_block, .redirect, .pc_r);
    coproc_model cop_u (.op_kind, .op_impl, .op_reject, .aux_decoded_op, .float_decoded_op,
        .coproc_valid_op, .aux_exception_in, .float_exception_in);

    // Clock at 25 MHz
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Default instruction fields; memory management present, ops implemented
    task clr;
        {is_rfi, is_block_zero, nocache_or_wt, is_word_excl, is_copro_ls, ls_size} <= '0;
        {is_float_instr, data_addr, opcode_illegal, is_privileged, is_tlb_instr} <= '0;
        {is_trap, trap_cond, op_kind, op_reject, instr_valid} <= '0;
        mmu_present_tie <= 1'b1;
        op_impl <= 1'b1;
    endtask

    // One APB transfer; holds the request until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next request never reassigns psel in this step
        @(posedge pclk);
    endtask

    // One instruction; block seen in its cycle, redirect after the taking edge
    task run(input logic [31:0] ia, input logic blk, input logic red, input logic [31:0] pce);
        instr_valid <= 1'b1; instr_addr <= ia;
        @(negedge pclk) chk(instr_block, blk);
        @(posedge pclk) clr;
        @(negedge pclk) chk(redirect, red);
        if (red) chk(pc_r, pce);
        @(posedge pclk);
    endtask

    task regs(input logic [31:0] ia, input logic [31:0] ms, input logic [31:0] sy);
        apb(0, `OFF_SAVE_ADDR, 0); chk(q, ia);
        apb(0, `OFF_SAVE_STATE, 0); chk(q, ms);
        apb(0, `OFF_MACHINE_STATE, 0); chk(q, ms & ~`MS_CLEAR_MASK);
        if (sy != 0) begin apb(0, `OFF_SYNDROME, 0); chk(q, sy); end
    endtask

    task al(input logic [5:0] f, input logic [31:0] a, input logic e);
        {is_block_zero, nocache_or_wt, is_word_excl, is_copro_ls, ls_size} <= f;
        data_addr <= a;
        run(32'h3000, e, e, {PFX, `VEC_ALIGN});
        if (e) begin apb(0, `OFF_FAULT_ADDR, 0); chk(q, a); end
    endtask

    task results;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #(40 * 4000);
        error_cnt++;
        results;
    end

    // Main sequence
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; instr_addr = 32'h0; clr;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(pc_r, `PC_RESET);
        apb(0, `OFF_MACHINE_STATE, 0); chk(q, `MS_RESET);
        apb(0, `OFF_PC, 0); chk(q, `PC_RESET);
        apb(0, 12'h020, 0); chk(q, 32'h0);
        apb(1, `OFF_VECTOR_PREFIX, {16'h0, PFX});
        apb(1, `OFF_SYNDROME, 32'h80400000);
        // Every program cause, machine-check flag kept, stale bits cleared
        for (i = 0; i < 7; i++) begin
            apb(1, `OFF_MACHINE_STATE, MS);
            case (i)
                0: opcode_illegal <= 1'b1;
                1: is_privileged <= 1'b1;
                2: begin is_trap <= 1'b1; trap_cond <= 1'b1; end
                3: begin op_kind <= 2'd1; op_impl <= 1'b0; end
                4: begin op_kind <= 2'd2; op_reject <= 1'b1; end
                5: begin op_kind <= 2'd1; op_reject <= 1'b1; end
                default: begin is_tlb_instr <= 1'b1; mmu_present_tie <= 1'b0; end
            endcase
            run(32'h1000 + 4 * i, 1, 1, {PFX, `VEC_PROGRAM});
            regs(32'h1000 + 4 * i, MS, 32'h80000000 | (32'h1 << sbit[i]));
        end
        is_rfi <= 1'b1;
        run(32'h2000, 0, 1, 32'h1018);
        apb(0, `OFF_MACHINE_STATE, 0); chk(q, MS);
        // Not faults: trap condition false, float op available and accepted
        is_trap <= 1'b1;
        run(32'h2004, 0, 0, 0);
        // Problem state with float available, so the float op is accepted
        apb(1, `OFF_MACHINE_STATE, 32'h00006000);
        op_kind <= 2'd2;
        run(32'h2008, 0, 0, 0);
        apb(1, `OFF_MACHINE_STATE, 32'h0);
        is_privileged <= 1'b1;
        run(32'h200c, 0, 0, 0);
        // Floating point unavailable
        apb(1, `OFF_MACHINE_STATE, 32'h00021200);
        op_kind <= 2'd2;
        run(32'h2010, 1, 1, {PFX, `VEC_FLOAT_UNAV});
        regs(32'h2010, 32'h00021200, 0);
        // Alignment cases, first with full state saved
        apb(1, `OFF_MACHINE_STATE, MS);
        al(6'b110000, 32'h80000100, 1);
        regs(32'h3000, MS, 0);
        al(6'b100000, 32'h100, 0);
        al(6'b001000, 32'h102, 1);
        al(6'b001000, 32'h104, 0);
        al(6'b000111, 32'h108, 1);
        al(6'b000111, 32'h110, 0);
        al(6'b000100, 32'h101, 1);
        al(6'b000100, 32'h102, 0);
        al(6'b000101, 32'h102, 1);
        al(6'b000110, 32'h104, 0);
        // Thirteen faults taken in all, the last one an alignment fault
        apb(0, `OFF_STATUS, 0); chk(q, 32'h0000030d);
        results;
    end
endmodule
`default_nettype wire
